// ### pkg/bpc_defines.svh
// timing and count constants for the burst and protection controller
// assumes a 25 MHz clock; included only by the controller module bpc_ctrl
`ifndef BPC_DEFINES_SVH
`define BPC_DEFINES_SVH
`define BPC_CLK_MHZ          25
`define BPC_SEL_TIMER_NS     2000
`define BPC_SEL_CYC          ((`BPC_SEL_TIMER_NS * `BPC_CLK_MHZ) / 1000)
`define BPC_BURST_BLANK_MS   20
`define BPC_BURST_BLANK_CYC  (`BPC_BURST_BLANK_MS * `BPC_CLK_MHZ * 1000)
`define BPC_ZC_MIN_LOW       4'h1
`define BPC_ZC_MIN_HIGH      4'h3
`define BPC_ZC_MAX_LOW       4'h8
`define BPC_ZC_MAX_HIGH      4'ha
`define BPC_OVP_PULSES       4'ha
`define BPC_SHORT_PULSES     2'h3
`endif

// ### pkg/bpc_pkg.sv
// shared types of the burst and protection controller
// no assumptions beyond the defines header
package bpc_pkg;
	typedef enum logic [1:0] {BPC_RUN, BPC_NS_AR, BPC_AR, BPC_ODD_AR} bpc_prot_e;
	typedef enum logic [1:0] {BPC_NORMAL, BPC_BURST_ON, BPC_BURST_OFF} bpc_mode_e;
endpackage

// ### pkg/bpc_gate_if.sv
// carrier between the controller and its on-time timer
// one clock domain
`timescale 1ns/1ns
interface bpc_gate_if;
	logic gate_on;
	logic on_expired;
	logic blank_done;
	modport ctrl (output gate_on, input on_expired, input blank_done);
	modport tmr  (input gate_on, output on_expired, output blank_done);
endinterface

// ### hw/bpc_on_timer.sv
// on-time timer: blanking and maximum on-time since gate turn-on
// gate_on comes from a flip-flop in the controller
`timescale 1ns/1ns
module bpc_on_timer #(
	parameter int LEB_CYC    = 8,
	parameter int ONMAX_CYC  = 500
) (
	input  wire logic clk,      // clock
	input  wire logic rst_n,    // sync reset, low
	bpc_gate_if.tmr   g         // gate link
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        exp;
		logic        blk;
	} bpc_tmr_s;
	bpc_tmr_s s_r, s_nxt;
	initial if (ONMAX_CYC <= LEB_CYC || ONMAX_CYC > 65535)
		$error("bpc_on_timer: bad timing parameters");
	always_comb
	begin
		s_nxt = s_r;
		if (!g.gate_on)
		begin
			s_nxt = '0;
		end
		else
		begin
			if (s_r.cnt != 16'hffff)
				s_nxt.cnt = s_r.cnt + 16'h0001;
			s_nxt.blk = (s_r.cnt >= 16'(LEB_CYC - 1));
			s_nxt.exp = (s_r.cnt >= 16'(ONMAX_CYC - 1));
		end
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
	assign g.on_expired = s_r.exp;
	assign g.blank_done = s_r.blk;
endmodule

// ### hw/bpc_ctrl.sv
// burst and protection controller of a quasi-resonant flyback
// inputs are comparator results synchronous to clk; outputs are flops
// Notes on behaviour
// - sense above current limit turns gate off at once.
// - current limit is ignored during blanking after each turn-on.
// - level 1 if sampled feedback above reference, else level 2.
// - detection latch cleared while reference-good is low.
// - latch clear and off: isolate feedback resistor, enable select source.
// - at supply-on sample feedback, set latch, then freeze level.
// - 2 us after supply-on, drop select source, reconnect resistor.
// - burst entry: feedback below entry, counter at max, for 20 ms.
// - burst: above on threshold switch at fixed max count, burst limit.
// - burst: at off threshold stop until on threshold again.
// - feedback above exit level leaves burst, full current limit.
// - leaving burst loads counter with 1 low line or 3 high line.
// - faults map to non-switch, plain or odd-skip auto restart.
// - overload masked in burst; vcc ovp, output ovp, short masked in burst off.
// - line overvoltage held while comparator reports above.
// - brownout entered below brownout, released above brown-in.
// - supply under/over voltage resets, restart after off then on.
// - overload only after feedback high for blanking time.
// - output overvoltage after 10 consecutive off-time pulses above.
// - over-temperature held until release indication.
// - sense short after 3 consecutive on-time pulses below threshold.
// - gate forced off past maximum on-time.
// - low line minimum count 1, high line minimum count 3.
// - turn-on after ring suppression only when zc count >= counter, or >= max count in burst.
`timescale 1ns/1ns
`include "bpc_defines.svh"
module bpc_ctrl #(
	parameter int BURST_BLANK_CYC = `BPC_BURST_BLANK_CYC,
	parameter int OLP_BLANK_CYC   = 1000,
	parameter int RESTART_CYC     = 10000,
	parameter int LEB_CYC         = 8,
	parameter int ONMAX_CYC       = 500
) (
	input  wire logic clk,               // clock
	input  wire logic rst_n,             // sync reset, low
	input  wire logic ref_good,          // internal reference good
	input  wire logic vcc_on,            // supply above turn-on threshold
	input  wire logic vcc_off,           // supply below turn-off threshold
	input  wire logic vcc_ov,            // supply overvoltage
	input  wire logic fb_above_ref,      // feedback above selection reference
	input  wire logic fb_below_entry,    // feedback below selected burst_entry_level
	input  wire logic fb_above_exit,     // feedback above burst_exit_level
	input  wire logic fb_above_bon,      // feedback above burst_on_threshold
	input  wire logic fb_below_boff,     // feedback at burst_off_threshold
	input  wire logic fb_above_olp,      // feedback above overload_threshold
	input  wire logic cs_over_limit,     // sense above active current limit
	input  wire logic cs_below_short,    // sense below sense_short_threshold
	input  wire logic zc_pulse,          // one zero crossing, pulse
	input  wire logic zc_above_ovp,      // zero_cross_pin above output ovp level
	input  wire logic ring_done,         // ring suppression over
	input  wire logic off_max,           // maximum off time reached
	input  wire logic line_high,         // line above line reference
	input  wire logic line_above_ovp,    // line above line_overvoltage_threshold
	input  wire logic line_below_bo,     // line below brownout_threshold
	input  wire logic line_above_bi,     // line above brown-in threshold
	input  wire logic ot_flag,           // over-temperature trip
	input  wire logic ot_release,        // over-temperature release
	input  wire logic [3:0] ud_count,    // up/down counter value outside
	output logic      gate_cmd,          // gate drive on
	output logic      ud_load,           // load up/down counter, pulse
	output logic [3:0] ud_load_val,      // value for up/down counter
	output logic      burst_level2,      // selected burst level 2
	output logic      burst_climit,      // use burst_current_limit
	output logic      sel_src_en,        // selection source on, resistor off
	output bpc_pkg::bpc_mode_e  mode,    // normal / burst phases
	output bpc_pkg::bpc_prot_e  prot     // active protection response
);
	import bpc_pkg::*;
	typedef struct packed {
		logic        gate;
		logic        latch;
		logic        lvl2;
		logic        src;
		logic [6:0]  sel_cnt;
		bpc_mode_e   mode;
		logic [31:0] bb_cnt;
		logic [31:0] olp_cnt;
		logic [31:0] rs_cnt;
		logic [3:0]  zc_cnt;
		logic [3:0]  ovp_cnt;
		logic        ovp_seen;
		logic [1:0]  sh_cnt;
		logic        sh_seen;
		logic        bo;
		logic        ot;
		logic        vcc_fault;
		logic        ov_fault;
		bpc_prot_e   prot;
		logic        odd;
		logic        ldv;
		logic [3:0]  ldval;
	} bpc_ctrl_s;
	bpc_ctrl_s s_r, s_nxt;
	bpc_gate_if gi ();
	initial if (BURST_BLANK_CYC < 1 || OLP_BLANK_CYC < 1 || RESTART_CYC < 1)
		$error("bpc_ctrl: counts must be positive");
	function automatic logic [3:0] zc_min(input logic hi);
		return hi ? `BPC_ZC_MIN_HIGH : `BPC_ZC_MIN_LOW;
	endfunction
	function automatic logic [3:0] zc_max(input logic hi);
		return hi ? `BPC_ZC_MAX_HIGH : `BPC_ZC_MAX_LOW;
	endfunction
	bpc_on_timer #(.LEB_CYC(LEB_CYC), .ONMAX_CYC(ONMAX_CYC)) u_tmr (
		.clk   (clk),
		.rst_n (rst_n),
		.g     (gi.tmr)
	);
	assign gi.gate_on = s_r.gate;
	always_comb
	begin
		logic run;
		logic turn_on;
		logic olp_hit;
		logic [3:0] need;
		run = 1'b0;
		turn_on = 1'b0;
		olp_hit = 1'b0;
		need = 4'h0;
		s_nxt = s_r;
		s_nxt.ldv = 1'b0;
		// detection latch and selection source
		if (!ref_good)
		begin
			s_nxt.latch = 1'b0;
			s_nxt.src = 1'b1;
			s_nxt.sel_cnt = '0;
		end
		else if (!s_r.latch)
		begin
			s_nxt.src = 1'b1;
			if (vcc_on)
			begin
				s_nxt.latch = 1'b1;
				s_nxt.lvl2 = !fb_above_ref;
			end
		end
		else if (s_r.src)
		begin
			s_nxt.sel_cnt = s_r.sel_cnt + 7'h01;
			if (s_r.sel_cnt >= 7'(`BPC_SEL_CYC - 1))
				s_nxt.src = 1'b0;
		end
		// supply faults reset the controller until off then on
		if (vcc_ov && s_r.mode != BPC_BURST_OFF)
			s_nxt.ov_fault = 1'b1;
		else if (vcc_off)
			s_nxt.ov_fault = 1'b0;
		if (vcc_off)
			s_nxt.vcc_fault = 1'b1;
		else if (s_r.vcc_fault && vcc_on && !vcc_ov)
			s_nxt.vcc_fault = 1'b0;
		// line protections are level driven
		if (line_below_bo)
			s_nxt.bo = 1'b1;
		else if (line_above_bi)
			s_nxt.bo = 1'b0;
		if (ot_flag)
			s_nxt.ot = 1'b1;
		else if (ot_release)
			s_nxt.ot = 1'b0;
		// overload timing, masked in both burst phases
		if (fb_above_olp && s_r.mode == BPC_NORMAL)
		begin
			if (s_r.olp_cnt < 32'(OLP_BLANK_CYC))
				s_nxt.olp_cnt = s_r.olp_cnt + 32'h1;
			else
				olp_hit = 1'b1;
		end
		else
			s_nxt.olp_cnt = '0;
		// protection supervisor
		run = (s_r.prot == BPC_RUN);
		if (s_r.vcc_fault || s_r.ov_fault)
		begin
			s_nxt.prot = s_r.ov_fault ? BPC_ODD_AR : BPC_AR;
			s_nxt.rs_cnt = '0;
		end
		else if (line_above_ovp || s_r.bo || s_r.ot)
		begin
			s_nxt.prot = BPC_NS_AR;
			s_nxt.rs_cnt = '0;
		end
		else if (run && (olp_hit || s_r.ovp_seen || s_r.sh_seen))
		begin
			s_nxt.prot = BPC_ODD_AR;
			s_nxt.rs_cnt = '0;
			s_nxt.odd = 1'b0;
		end
		else if (!run)
		begin
			// odd skip waits two restart intervals before every restart attempt
			s_nxt.rs_cnt = s_r.rs_cnt + 32'h1;
			if (s_r.rs_cnt >= 32'(RESTART_CYC - 1))
			begin
				s_nxt.rs_cnt = '0;
				if (s_r.prot == BPC_ODD_AR && !s_r.odd)
					s_nxt.odd = 1'b1;
				else
				begin
					s_nxt.prot = BPC_RUN;
					s_nxt.mode = BPC_NORMAL;
					s_nxt.ldv = 1'b1;
					s_nxt.ldval = zc_min(line_high);
					s_nxt.ovp_seen = 1'b0;
					s_nxt.sh_seen = 1'b0;
					s_nxt.ovp_cnt = '0;
					s_nxt.sh_cnt = '0;
				end
			end
		end
		if (s_nxt.prot != BPC_RUN)
			s_nxt.gate = 1'b0;
		// zero-crossing count, cleared at each turn-on
		if (s_r.gate)
			s_nxt.zc_cnt = '0;
		else if (zc_pulse && s_r.zc_cnt != 4'hf)
			s_nxt.zc_cnt = s_r.zc_cnt + 4'h1;
		// burst mode sequencing
		case (s_r.mode)
			BPC_NORMAL:
			begin
				if (fb_below_entry && ud_count == zc_max(line_high))
				begin
					if (s_r.bb_cnt < 32'(BURST_BLANK_CYC - 1))
						s_nxt.bb_cnt = s_r.bb_cnt + 32'h1;
					else
					begin
						s_nxt.mode = BPC_BURST_ON;
						s_nxt.bb_cnt = '0;
					end
				end
				else
					s_nxt.bb_cnt = '0;
			end
			BPC_BURST_ON:
			begin
				if (fb_below_boff)
					s_nxt.mode = BPC_BURST_OFF;
			end
			BPC_BURST_OFF:
			begin
				if (fb_above_bon)
					s_nxt.mode = BPC_BURST_ON;
			end
			default:
				s_nxt.mode = BPC_NORMAL;
		endcase
		if (s_r.mode != BPC_NORMAL && fb_above_exit)
		begin
			s_nxt.mode = BPC_NORMAL;
			s_nxt.ldv = 1'b1;
			s_nxt.ldval = zc_min(line_high);
		end
		// gate on/off
		need = (s_r.mode == BPC_NORMAL) ? ud_count : zc_max(line_high);
		turn_on = !s_r.gate && run && s_r.latch && !s_r.src
			&& s_r.mode != BPC_BURST_OFF
			&& ((ring_done && s_r.zc_cnt >= need) || off_max);
		if (s_r.gate)
		begin
			if (gi.on_expired)
				s_nxt.gate = 1'b0;
			else if (cs_over_limit && gi.blank_done)
				s_nxt.gate = 1'b0;
			if (s_r.mode == BPC_BURST_OFF)
				s_nxt.gate = 1'b0;
		end
		else if (turn_on)
			s_nxt.gate = 1'b1;
		// output ovp judged on the last off-time cycle, once per off-time pulse
		if (!s_r.gate && s_nxt.gate)                          // no turn-on in burst off
		begin
			if (zc_above_ovp)
			begin
				s_nxt.ovp_cnt = s_r.ovp_cnt + 4'h1;
				if (s_r.ovp_cnt >= `BPC_OVP_PULSES - 4'h1)
					s_nxt.ovp_seen = 1'b1;
			end
			else
				s_nxt.ovp_cnt = '0;
		end
		if (s_r.gate && !s_nxt.gate && s_r.mode != BPC_BURST_OFF)
		begin
			// sense short judged at the end of each on-time outside burst off
			if (cs_below_short && gi.blank_done)
			begin
				s_nxt.sh_cnt = s_r.sh_cnt + 2'h1;
				if (s_r.sh_cnt >= `BPC_SHORT_PULSES - 2'h1)
					s_nxt.sh_seen = 1'b1;
			end
			else
				s_nxt.sh_cnt = '0;
		end
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_r <= '0;
			s_r.src <= 1'b1;
			s_r.vcc_fault <= 1'b1;
			s_r.prot <= BPC_AR;
		end
		else
			s_r <= s_nxt;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			gate_cmd <= 1'b0;
			ud_load <= 1'b0;
			ud_load_val <= 4'h0;
			burst_level2 <= 1'b0;
			burst_climit <= 1'b0;
			sel_src_en <= 1'b1;
			mode <= BPC_NORMAL;
			prot <= BPC_AR;
		end
		else
		begin
			gate_cmd <= s_nxt.gate;
			ud_load <= s_nxt.ldv;
			ud_load_val <= s_nxt.ldval;
			burst_level2 <= s_nxt.lvl2;
			burst_climit <= (s_nxt.mode != BPC_NORMAL);
			sel_src_en <= s_nxt.src;
			mode <= s_nxt.mode;
			prot <= s_nxt.prot;
		end
	end
endmodule

// ### verification/bpc_ctrl_asserts.sv
// checker: port timing of the burst and protection controller
// bound to every bpc_ctrl; one clock, synchronous active-low reset
`timescale 1ns/1ns
module bpc_ctrl_asserts
	import bpc_pkg::*;
#(
	parameter int LEB_CYC   = 8,
	parameter int ONMAX_CYC = 500
) (
	input wire logic       clk,            // clock
	input wire logic       rst_n,          // reset, low
	input wire logic       cs_over_limit,  // sense above limit
	input wire logic       ring_done,      // ringing over
	input wire logic       off_max,        // off time limit
	input wire logic       fb_below_entry, // below entry level
	input wire logic       fb_above_exit,  // above exit level
	input wire logic       line_high,      // high line
	input wire logic       line_above_ovp, // line overvoltage
	input wire logic [3:0] ud_count,       // up/down count
	input wire logic       gate_cmd,       // gate on
	input wire logic       ud_load,        // counter load
	input wire logic [3:0] ud_load_val,    // load value
	input wire logic       burst_climit,   // burst limit
	input wire logic       sel_src_en,     // select source
	input wire bpc_mode_e  mode,           // mode
	input wire bpc_prot_e  prot            // protection
);
	logic [15:0] on_cnt_r;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			on_cnt_r <= 16'h0;
		else
			on_cnt_r <= gate_cmd ? on_cnt_r + 16'h1 : 16'h0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_CS_CUT: assert property (
		gate_cmd && cs_over_limit && on_cnt_r > LEB_CYC + 1 |=> !gate_cmd)
		else $error("gate kept on after current limit");
	AST_BLANK: assert property (
		gate_cmd && cs_over_limit && on_cnt_r < LEB_CYC - 1 |=> gate_cmd)
		else $error("current limit acted inside blanking");
	AST_MAX_ON: assert property (
		gate_cmd |-> on_cnt_r <= ONMAX_CYC + 2)
		else $error("on-time beyond its limit");
	AST_TURN_ON: assert property (
		$rose(gate_cmd) |-> ($past(ring_done) || $past(off_max)) && !$past(sel_src_en)
		&& $past(prot) == BPC_RUN)
		else $error("turn-on without its conditions");
	AST_BURST_OFF: assert property (
		mode == BPC_BURST_OFF && $past(mode) == BPC_BURST_OFF |-> !gate_cmd)
		else $error("switching in burst off phase");
	AST_ENTRY: assert property (
		mode == BPC_BURST_ON && $past(mode) == BPC_NORMAL |-> $past(fb_below_entry)
		&& $past(ud_count) == ($past(line_high) ? 4'ha : 4'h8))
		else $error("burst entered without its conditions");
	AST_EXIT: assert property (
		mode == BPC_NORMAL && $past(mode) != BPC_NORMAL && $past(fb_above_exit)
		&& prot == BPC_RUN |-> ud_load && !burst_climit
		&& ud_load_val == ($past(line_high) ? 4'h3 : 4'h1))
		else $error("burst exit without counter load");
	AST_LINE_OVP: assert property (
		line_above_ovp && prot == BPC_RUN |=> prot == BPC_NS_AR)
		else $error("line overvoltage not taken");
endmodule
bind bpc_ctrl bpc_ctrl_asserts #(.LEB_CYC(LEB_CYC), .ONMAX_CYC(ONMAX_CYC)) u_chk (
	.clk(clk), .rst_n(rst_n), .cs_over_limit(cs_over_limit), .ring_done(ring_done),
	.off_max(off_max), .fb_below_entry(fb_below_entry), .fb_above_exit(fb_above_exit),
	.line_high(line_high), .line_above_ovp(line_above_ovp), .ud_count(ud_count),
	.gate_cmd(gate_cmd), .ud_load(ud_load), .ud_load_val(ud_load_val),
	.burst_climit(burst_climit), .sel_src_en(sel_src_en), .mode(mode), .prot(prot)
);

// ### verification/bpc_stage_model.sv
// power stage and comparator front-end seen by the controller
// same clock as the controller; the bench sets trip point and faults
`timescale 1ns/1ns
module bpc_stage_model (
	input  wire logic       clk,            // clock
	input  wire logic       rst_n,          // reset, low
	input  wire logic       gate_cmd,       // gate drive
	input  wire logic [7:0] cs_at,          // on cycles to limit, 0 never
	input  wire logic       short_en,       // sense pin shorted
	input  wire logic       ovp_en,         // output overvoltage
	output logic            zc_pulse,       // valley pulse
	output logic            ring_done,      // ringing over
	output logic            cs_over_limit,  // sense above limit
	output logic            cs_below_short, // sense below short level
	output logic            zc_above_ovp    // zc pin above ovp level
);
	logic [7:0] on_r;
	logic [7:0] off_r;
	always_ff @(posedge clk)
	begin
		on_r  <= (gate_cmd && rst_n) ? on_r + 8'h1 : 8'h0;
		off_r <= (!gate_cmd && rst_n) ? off_r + 8'h1 : 8'h0;
	end
	// valleys only every second cycle, so high counts take real time
	assign ring_done      = !gate_cmd && off_r > 8'h3;
	assign zc_pulse       = ring_done && off_r[0];
	assign cs_over_limit  = gate_cmd && !short_en && cs_at != 8'h0 && on_r >= cs_at;
	assign cs_below_short = gate_cmd && short_en;
	assign zc_above_ovp   = !gate_cmd && ovp_en;
endmodule

// ### verification/burst_and_protection_ctrl_tb.sv
// self-checking bench of bpc_ctrl with the stage model on its far side
// short counts set by parameters; expectations derived from them
`timescale 1ns/1ns
module burst_and_protection_ctrl_tb;
	import bpc_pkg::*;
	localparam int BB = 50;
	localparam int OB = 30;
	localparam int RS = 20;
	localparam int LEB = 8;
	localparam int OM = 60;
	logic clk = 0, rst_n = 0, ref_good = 0, vcc_on = 0, vcc_off = 1, vcc_ov = 0;
	logic fb_above_ref = 0, fb_below_entry = 0, fb_above_exit = 0, fb_above_bon = 0;
	logic fb_below_boff = 0, fb_above_olp = 0, line_high = 0, line_above_ovp = 0;
	logic line_below_bo = 0, line_above_bi = 1, ot_flag = 0, ot_release = 1;
	logic short_en = 0, ovp_en = 0, zc_pulse, ring_done, cs_over_limit, cs_below_short;
	logic zc_above_ovp, gate_cmd, ud_load, burst_level2, burst_climit, sel_src_en;
	logic [3:0] ud_count = 4'h1, ud_load_val;
	logic [7:0] cs_at = 8'h0;
	bpc_mode_e mode;
	bpc_prot_e prot;
	int n_fail = 0, comparisons = 0, cyc = 0;
	always #20 clk = ~clk;
	bpc_ctrl #(.BURST_BLANK_CYC(BB), .OLP_BLANK_CYC(OB), .RESTART_CYC(RS), .LEB_CYC(LEB),
		.ONMAX_CYC(OM)) dut (.clk, .rst_n, .ref_good, .vcc_on, .vcc_off, .vcc_ov,
		.fb_above_ref, .fb_below_entry, .fb_above_exit, .fb_above_bon, .fb_below_boff,
		.fb_above_olp, .cs_over_limit, .cs_below_short, .zc_pulse, .zc_above_ovp,
		.ring_done, .off_max(1'b0), .line_high, .line_above_ovp, .line_below_bo,
		.line_above_bi, .ot_flag, .ot_release, .ud_count, .gate_cmd, .ud_load,
		.ud_load_val, .burst_level2, .burst_climit, .sel_src_en, .mode, .prot);
	bpc_stage_model stage (.clk, .rst_n, .gate_cmd, .cs_at, .short_en, .ovp_en, .zc_pulse,
		.ring_done, .cs_over_limit, .cs_below_short, .zc_above_ovp);
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic wait_st(input logic is_prot, input logic [1:0] e, input int lim);
		for (int i = 0; i < lim && (is_prot ? prot : mode) !== e; i++)
			tick(1);
		chk(is_prot ? "prot" : "mode", e, is_prot ? prot : mode);
	endtask
	// width of the next gate pulse; 0 if none comes
	task automatic on_width(output int w);
		int i;
		for (i = 0; i < 500 && gate_cmd !== 1'b0; i++)
			tick(1);
		for (i = 0; i < 500 && gate_cmd !== 1'b1; i++)
			tick(1);
		for (w = 0; w < 500 && gate_cmd === 1'b1; w++)
			tick(1);
	endtask
	task automatic resupply(input logic down);
		if (down)
		begin
			vcc_on = 0;
			vcc_off = 1;
			tick(3);
		end
		vcc_on = 1;
		vcc_off = 0;
		wait_st(1, BPC_RUN, 4 * RS + 80);
	endtask
	task automatic t_start(input logic r);
		vcc_on = 0;
		vcc_off = 1;
		ref_good = 0;
		tick(3);
		chk("sel_src_en", 1, sel_src_en);
		ref_good = 1;
		fb_above_ref = r;
		tick(2);
		vcc_on = 1;
		vcc_off = 0;
		tick(2);
		fb_above_ref = !r;
		tick(40);
		chk("burst_level2", !r, burst_level2);
		chk("sel_src_en", 1, sel_src_en);
		tick(15);
		chk("sel_src_en", 0, sel_src_en);
		wait_st(1, BPC_RUN, 4 * RS);
	endtask
	task automatic t_switch;
		int w;
		for (int k = 0; k < 3; k++)
		begin
			cs_at = k == 0 ? 8'h3 : k == 1 ? 8'hc : 8'h0;
			on_width(w);
			w -= k == 0 ? LEB : k == 1 ? 12 : OM;
			chk("on_width", 1, w >= 0 && w <= 2);
		end
	endtask
	task automatic t_burst;
		int w;
		for (int h = 0; h < 2; h++)
		begin
			line_high = h;
			ud_count = h ? 4'h9 : 4'h7;
			fb_below_entry = 1;
			tick(BB + 10);
			chk("mode", BPC_NORMAL, mode);
			ud_count = h ? 4'ha : 4'h8;
			tick(BB - 10);
			chk("mode", BPC_NORMAL, mode);
			wait_st(0, BPC_BURST_ON, 30);
			chk("burst_climit", 1, burst_climit);
			fb_below_entry = 0;
			fb_below_boff = 1;
			wait_st(0, BPC_BURST_OFF, 3);
			fb_above_olp = 1;
			tick(OB + 10);
			chk("prot", BPC_RUN, prot);
			fb_above_olp = 0;
			fb_below_boff = 0;
			tick(5);
			chk("mode", BPC_BURST_OFF, mode);
			fb_above_bon = 1;
			on_width(w);
			chk("burst_pulse", 1, w > 0 && mode === BPC_BURST_ON);
			fb_above_exit = 1;
			wait_st(0, BPC_NORMAL, 5);
			chk("ud_load", 1, ud_load);
			chk("ud_load_val", h ? 4'h3 : 4'h1, ud_load_val);
			chk("burst_climit", 0, burst_climit);
			fb_above_exit = 0;
			fb_above_bon = 0;
			ud_count = h ? 4'h3 : 4'h1;
		end
	endtask
	task automatic t_prot;
		line_above_ovp = 1;
		wait_st(1, BPC_NS_AR, 4);
		line_above_ovp = 0;
		wait_st(1, BPC_RUN, 2 * RS + 10);
		line_above_bi = 0;
		line_below_bo = 1;
		wait_st(1, BPC_NS_AR, 4);
		line_below_bo = 0;
		tick(2 * RS + 10);
		chk("prot", BPC_NS_AR, prot);
		line_above_bi = 1;
		wait_st(1, BPC_RUN, 2 * RS + 10);
		ot_release = 0;
		ot_flag = 1;
		wait_st(1, BPC_NS_AR, 4);
		ot_flag = 0;
		tick(2 * RS + 10);
		chk("prot", BPC_NS_AR, prot);
		ot_release = 1;
		wait_st(1, BPC_RUN, 2 * RS + 10);
		fb_above_olp = 1;
		tick(OB - 5);
		chk("prot", BPC_RUN, prot);
		wait_st(1, BPC_ODD_AR, 15);
		fb_above_olp = 0;
		wait_st(1, BPC_RUN, 4 * RS + 20);
		vcc_ov = 1;
		wait_st(1, BPC_ODD_AR, 4);
		vcc_ov = 0;
		resupply(1);
		vcc_on = 0;
		vcc_off = 1;
		wait_st(1, BPC_AR, 4);
		resupply(0);
	endtask
	task automatic t_count(input logic sh);
		int n;
		logic g0;
		n = 0;
		g0 = 1;
		short_en = sh;
		ovp_en = !sh;
		cs_at = sh ? 8'h0 : 8'hc;
		for (int i = 0; i < 4000 && prot === BPC_RUN; i++)
		begin
			n += gate_cmd === 1'b1 && !g0;
			g0 = gate_cmd;
			tick(1);
		end
		n -= sh ? 3 : 10;
		chk("pulses", 1, n >= 0 && n <= 1);
		chk("prot", BPC_ODD_AR, prot);
		short_en = 0;
		ovp_en = 0;
		cs_at = 8'h0;
		wait_st(1, BPC_RUN, 4 * RS + 20);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	initial
	begin
		tick(20);
		rst_n = 1;
		t_start(0);
		t_switch();
		t_burst();
		t_prot();
		t_count(1);
		t_count(0);
		t_start(1);
		give_verdict();
	end
endmodule
